// ### core/cmw_defines.vh
`ifndef CMW_DEFINES_VH
`define CMW_DEFINES_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define CMW_MODE_INDEX      8'hd9
`define CMW_ADDR_MODE       12'h0364
`define CMW_ADDR_CTRL       12'h0000
`define CMW_ADDR_STATUS     12'h0004
`define CMW_ADDR_CLEAR      12'h0008
`define CMW_ADDR_ENABLE     12'h000c
`define CMW_ADDR_COUNT      12'h0010

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define CMW_BIT_IDLE        7
`define CMW_BIT_WDE         6
`define CMW_BIT_LOCK        5
`define CMW_BIT_UNUSED      4
`define CMW_TB_HI           3
`define CMW_TB_LO           1
`define CMW_BIT_OVIM        0
`define CMW_MODE_RESET      8'h40

// ----------------------------------------------------------------
// Timebase codes
// ----------------------------------------------------------------
`define CMW_TB_DIV12        3'h0
`define CMW_TB_DIV4         3'h1
`define CMW_TB_T0OV         3'h2
`define CMW_TB_ECI          3'h3
`define CMW_TB_SYS          3'h4
`define CMW_TB_EXT8         3'h5

// ----------------------------------------------------------------
// Status bits and divider counts
// ----------------------------------------------------------------
`define CMW_ST_OVF          0
`define CMW_ST_WRAP         1
`define CMW_DIV12_LAST      4'h0b
`define CMW_DIV4_LAST       4'h3
`define CMW_EXT_DIV_LAST    3'h7
`define CMW_COUNT_MAX       16'hffff

`endif

// ### core/cmw_counter_mode.v
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "cmw_defines.vh"
// Overview of operation
// RULE1 - Mode bit 7 set halts the counter while the system is idle.
// RULE2 - Mode bit 6 enables the watchdog and drives the watchdog output.
// RULE3 - The mode register resets with only the watchdog enable set.
// RULE4 - With the lock bit 5 set, the watchdog cannot be disabled.
// RULE5 - Bit 4 reads zero and ignores writes.
// RULE6 - Bits 3:1 pick the timebase; codes 110 and 111 give no counts.
// RULE7 - Code 011 counts falling edges of the external count input.
// RULE8 - Code 101 counts an external clock divided by 8, synchronised.
// RULE9 - Bit 0 lets a set overflow flag raise the interrupt request.
// RULE10 - Wrap from all ones sets the overflow flag; software clears it.
// RULE11 - While the watchdog is enabled mode bits other than the enable and the lock are frozen.
// RULE12 - Software can never clear the lock bit; only reset does.
module cmw_counter_mode (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        cpu_idle,
  input  wire        timer0_overflow,
  input  wire        external_count_input,
  input  wire        external_clock,
  output reg         watchdog_active,
  output reg         counter_tick,
  output reg         irq
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire        access;
  wire        wr;
  wire        hit_md;
  wire        hit_ct;
  wire        hit_st;
  wire        hit_cl;
  wire        hit_en;
  wire        hit_cn;
  wire        mapped;

  assign access = psel & penable;
  // A write lands only at the edge that completes the access phase
  assign wr     = access & pwrite & pready;
  assign hit_md = (paddr == `CMW_ADDR_MODE);
  assign hit_ct = (paddr == `CMW_ADDR_CTRL);
  assign hit_st = (paddr == `CMW_ADDR_STATUS);
  assign hit_cl = (paddr == `CMW_ADDR_CLEAR);
  assign hit_en = (paddr == `CMW_ADDR_ENABLE);
  assign hit_cn = (paddr == `CMW_ADDR_COUNT);
  assign mapped = hit_md | hit_ct | hit_st | hit_cl | hit_en | hit_cn;

  // Software visible state
  reg  [7:0]  mode;
  reg         run;
  reg  [1:0]  status;
  reg  [1:0]  irq_en;
  reg  [15:0] count;

  // Prescaler phases
  reg  [3:0]  div;
  reg  [2:0]  ext_div;

  // Synchronisers; the third stage only feeds the edge detectors
  reg         eci_s1;
  reg         eci_s2;
  reg         eci_s3;
  reg         ext_s1;
  reg         ext_s2;
  reg         ext_s3;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // The two timebases that run from the cycle prescaler
  function is_prescaled;
    input [2:0] code;
    begin
      is_prescaled = (code == `CMW_TB_DIV12) || (code == `CMW_TB_DIV4);
    end
  endfunction

  // ----------------------------------------------------------------
  // Mode register write
  // ----------------------------------------------------------------
  // Clearing the enable and setting the lock are the only changes software
  // can make while the watchdog runs; once the lock is set the enable cannot be cleared
  reg [7:0] next_mode;
  always @* begin
    next_mode = mode;
    if (wr && hit_md) begin
      if (!mode[`CMW_BIT_WDE]) begin
        next_mode = pwdata[7:0];                              // [RULE11]
      end
      // Lock forces the enable on and sticks until reset
      next_mode[`CMW_BIT_LOCK] = mode[`CMW_BIT_LOCK] |
                                 pwdata[`CMW_BIT_LOCK];        // [RULE12]
      next_mode[`CMW_BIT_WDE]  = pwdata[`CMW_BIT_WDE] |
                                 next_mode[`CMW_BIT_LOCK];     // [RULE4]
      next_mode[`CMW_BIT_UNUSED] = 1'b0;                      // [RULE5]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= `CMW_MODE_RESET;                                // [RULE3]
    end else begin
      mode <= next_mode;
    end
  end

  // ----------------------------------------------------------------
  // Timebase selection
  // ----------------------------------------------------------------
  wire [2:0] tb;
  wire       halted;
  wire       going;
  wire       pre;
  wire       eci_fall;
  wire       ext_rise;
  wire       ext_tick;

  assign tb       = mode[`CMW_TB_HI:`CMW_TB_LO];
  assign halted   = mode[`CMW_BIT_IDLE] & cpu_idle;           // [RULE1]
  // Watchdog forces the counter on regardless of the run bit
  assign going    = (run | mode[`CMW_BIT_WDE]) & ~halted;
  assign pre      = is_prescaled(tb);
  assign eci_fall = eci_s3 & ~eci_s2;                         // [RULE7]
  assign ext_rise = ext_s2 & ~ext_s3;
  assign ext_tick = ext_rise && (ext_div == `CMW_EXT_DIV_LAST); // [RULE8]

  // Reserved codes give no counts, so a stray code stops the counter
  reg tick;
  always @* begin
    case (tb)                                                 // [RULE6]
      `CMW_TB_DIV12: tick = (div == `CMW_DIV12_LAST);
      `CMW_TB_DIV4:  tick = (div == `CMW_DIV4_LAST);
      `CMW_TB_T0OV:  tick = timer0_overflow;
      `CMW_TB_ECI:   tick = eci_fall;
      `CMW_TB_SYS:   tick = 1'b1;
      `CMW_TB_EXT8:  tick = ext_tick;
      default:       tick = 1'b0;
    endcase
  end

  // The wrap event is the tick that moves the count from all ones
  wire wrap = going & tick & (count == `CMW_COUNT_MAX);

  // Synchronisers: first stage is read only by the second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eci_s1 <= 1'b0;
      eci_s2 <= 1'b0;
      eci_s3 <= 1'b0;
    end else begin
      eci_s1 <= external_count_input;
      eci_s2 <= eci_s1;
      eci_s3 <= eci_s2;
    end
  end

  // External clock path, same depth as the count input
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      ext_s1 <= external_clock;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;                                       // [RULE8]
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and counter
  // ----------------------------------------------------------------
  // Cycle prescaler holds its phase while the counter is stopped.
  // A switch between the two prescaled bases keeps the phase, so the
  // first period after such a switch can run long.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 4'h0;
    end else if (going && pre) begin
      if (tick) begin
        div <= 4'h0;
      end else begin
        div <= div + 4'h1;
      end
    end
  end

  // External clock divider counts every synchronised rising edge while the counter is going
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_div <= 3'h0;
    end else if (going && ext_rise) begin
      ext_div <= ext_div + 3'h1;
    end
  end

  // Count is read-only to software while the watchdog runs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 16'h0000;
    end else if (wr && hit_cn && !mode[`CMW_BIT_WDE]) begin
      count <= pwdata[15:0];
    end else if (going && tick) begin
      count <= count + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Control, status and interrupt
  // ----------------------------------------------------------------
  wire [1:0] events;
  wire [1:0] clr;

  // Both status bits record the same wrap event
  assign events = {wrap, wrap};
  assign clr    = (wr && hit_cl) ? pwdata[1:0] : 2'b00;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run     <= 1'b0;
      status  <= 2'b00;
      irq_en  <= 2'b00;
    end else begin
      // The run bit keeps the software value; the watchdog overrides it
      if (wr && hit_ct) begin
        run <= pwdata[0];
      end
      // Set wins over a clear in the same cycle
      status <= (status & ~clr) | events;                     // [RULE10]
      if (wr && hit_en) begin
        irq_en <= pwdata[1:0];
      end
    end
  end

  wire ovf_req;
  wire gen_req;

  assign ovf_req = status[`CMW_ST_OVF] & mode[`CMW_BIT_OVIM]; // [RULE9]
  assign gen_req = |(status & irq_en);

  // ----------------------------------------------------------------
  // Registered outputs and read data
  // ----------------------------------------------------------------
  // Read data is captured in the first access cycle and stands with
  // pready; the clear offset and unmapped offsets read as zero
  reg [31:0] rdata;
  always @* begin
    rdata = 32'h0000_0000;
    if (hit_md) begin
      rdata[7:0] = mode;
    end else if (hit_ct) begin
      rdata[0] = run;
    end else if (hit_st) begin
      rdata[1:0] = status;
    end else if (hit_en) begin
      rdata[1:0] = irq_en;
    end else if (hit_cn) begin
      rdata[15:0] = count;
    end
  end

  // One wait state: pready rises in the second access cycle, so the
  // address decode has a whole period to settle before read data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      if (access && !pready && !pwrite) begin
        prdata <= rdata;
      end
    end
  end

  // The watchdog output follows next_mode so it never lags the register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_active <= 1'b1;
      counter_tick    <= 1'b0;
      irq             <= 1'b0;
    end else begin
      watchdog_active <= next_mode[`CMW_BIT_WDE];             // [RULE2]
      counter_tick    <= going & tick;
      irq             <= ovf_req | gen_req;                   // [RULE9]
    end
  end

endmodule // cmw_counter_mode

// ### testbench/cmw_props.sv
`timescale 1ns/1ps
`include "cmw_defines.vh"
module cmw_props (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        cpu_idle,
  input wire        timer0_overflow,
  input wire        external_count_input,
  input wire        external_clock,
  input wire        watchdog_active,
  input wire        counter_tick,
  input wire        irq
);
  // --------------------------------------------------------------
  // Bus and watchdog enable relations
  // --------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel & penable & pready;
  wire mw  = acc & pwrite & (paddr == `CMW_ADDR_MODE);
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  answer_time_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer in second access cycle");
  ready_place_a: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  unmapped_err_a: assert property (pready && paddr > `CMW_ADDR_COUNT &&
    paddr != `CMW_ADDR_MODE |-> pslverr) else $error("no slave error");
  wd_reset_a: assert property ($rose(presetn) |-> watchdog_active)
    else $error("watchdog off after reset");
  wd_set_a: assert property (mw && pwdata[6] |=> watchdog_active)
    else $error("watchdog not enabled by write");
  lock_on_a: assert property (mw && pwdata[5] |=> watchdog_active)
    else $error("lock did not keep watchdog on");
  unused_bit_a: assert property (acc && !pwrite &&
    paddr == `CMW_ADDR_MODE |-> prdata[31:8] == 0 && !prdata[4])
    else $error("unused mode bits not zero");
endmodule // cmw_props

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`include "cmw_defines.vh"
module tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, v;
  logic        pready, pslverr, e, watchdog_active, counter_tick, irq;
  logic        cpu_idle = 0, timer0_overflow = 0;
  logic        external_count_input = 0, external_clock = 0;
  int          failures = 0, checked = 0, cyc = 0;
  always #20 pclk = ~pclk;
  cmw_counter_mode i_dut (.*);
  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task print_verdict;
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Extra idle edge keeps back-to-back calls from driving psel twice
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 0, 0);
    chk(r, exp);
  endtask
  // Outputs are registered: let two edges pass before looking
  task late(input logic sel, input logic exp);
    repeat (2) @(posedge pclk);
    chk(sel ? irq : watchdog_active, exp);
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task t_frozen;
    rd(`CMW_ADDR_MODE, 32'h0000_0040);
    late(0, 1);
    wr(`CMW_ADDR_MODE, 32'h0000_009f);
    rd(`CMW_ADDR_MODE, 32'h0000_0000);
    late(0, 0);
    for (int c = 0; c < 8; c++) begin
      wr(`CMW_ADDR_MODE, 32'h0000_0010 | (c << 1));
      rd(`CMW_ADDR_MODE, c << 1);
    end
    wr(`CMW_ADDR_MODE, 32'h0000_0040);
    late(0, 1);
    wr(`CMW_ADDR_MODE, 32'h0000_004e);
    rd(`CMW_ADDR_MODE, 32'h0000_0040);
    wr(`CMW_ADDR_MODE, 32'h0000_0000);
  endtask
  // Ticks counted over 48 cycles after the prescaler has settled
  task t_div(input logic [2:0] c, input logic [31:0] exp);
    wr(`CMW_ADDR_MODE, {28'h000_0000, c, 1'b0});
    repeat (20) @(posedge pclk);
    v = 0;
    repeat (48) begin
      @(posedge pclk);
      v = v + counter_tick;
    end
    chk(v, exp);
  endtask
  task t_src(input logic [2:0] c, input int n, input logic [31:0] exp);
    wr(`CMW_ADDR_MODE, {28'h000_0000, c, 1'b0});
    wr(`CMW_ADDR_COUNT, 32'h0000_0000);
    repeat (n) begin
      timer0_overflow <= (c == 3'h2);
      external_count_input <= (c == 3'h3);
      external_clock <= (c == 3'h5);
      @(posedge pclk);
      {timer0_overflow, external_count_input, external_clock} <= 3'h0;
      repeat (3) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
    rd(`CMW_ADDR_COUNT, exp);
  endtask
  task t_ovf;
    wr(`CMW_ADDR_MODE, 32'h0000_0009);
    wr(`CMW_ADDR_COUNT, 32'h0000_fffe);
    repeat (8) @(posedge pclk);
    rd(`CMW_ADDR_STATUS, 32'h0000_0003);
    late(1, 1);
    wr(`CMW_ADDR_MODE, 32'h0000_0008);
    late(1, 0);
    rd(`CMW_ADDR_STATUS, 32'h0000_0003);
    wr(`CMW_ADDR_ENABLE, 32'h0000_0001);
    late(1, 1);
    wr(`CMW_ADDR_CLEAR, 32'h0000_0003);
    rd(`CMW_ADDR_STATUS, 32'h0000_0000);
    late(1, 0);
  endtask
  task t_idle;
    wr(`CMW_ADDR_MODE, 32'h0000_0088);
    cpu_idle <= 1;
    apb(`CMW_ADDR_COUNT, 0, 0);
    v = r;
    repeat (10) @(posedge pclk);
    chk(counter_tick, 0);
    rd(`CMW_ADDR_COUNT, v);
    wr(`CMW_ADDR_MODE, 32'h0000_0008);
    apb(`CMW_ADDR_COUNT, 0, 0);
    chk(r !== v, 1);
    chk(counter_tick, 1);
    cpu_idle <= 0;
  endtask
  task t_lock;
    wr(`CMW_ADDR_MODE, 32'h0000_0020);
    rd(`CMW_ADDR_MODE, 32'h0000_0060);
    wr(`CMW_ADDR_MODE, 32'h0000_0000);
    rd(`CMW_ADDR_MODE, 32'h0000_0060);
    late(0, 1);
    apb(12'h0fc, 0, 0);
    chk(e, 1);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    t_frozen;
    wr(`CMW_ADDR_CTRL, 32'h0000_0001);
    t_src(3'h2, 5, 32'h0000_0005);
    t_src(3'h3, 4, 32'h0000_0004);
    t_src(3'h5, 16, 32'h0000_0002);
    t_div(3'h1, 32'h0000_000c);
    t_div(3'h0, 32'h0000_0004);
    t_div(3'h6, 32'h0000_0000);
    t_ovf;
    t_idle;
    t_lock;
    print_verdict;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      $display("ERROR %0t timeout", $time);
      print_verdict;
    end
  end
endmodule // tb_top
bind cmw_counter_mode cmw_props i_props (.*);
